/* File: design/adc_ctrl_pkg.sv */
// Purpose: Shared constants and types for the converter control registers
// Assumes: Registers reached over AXI4-Lite, byte address is four times the index
// Notes: Register bytes sit in the low lane, upper bits read as zero

package adc_ctrl_pkg;

  // ==========================================================================
  // Bus widths and responses
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register indices (byte address = index * 4)
  localparam logic [5:0] IDX_STATUS_CONTROL = 6'h3C;
  localparam logic [5:0] IDX_RESULT_HIGH = 6'h3D;
  localparam logic [5:0] IDX_RESULT_LOW = 6'h3E;
  localparam logic [5:0] IDX_CLOCK_CONFIG = 6'h3F;

  // ==========================================================================
  // Status and control fields
  localparam int FLAG_BIT = 7;
  localparam int IEN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int CH_LSB = 0;
  localparam int CH_W = 5;
  localparam logic [7:0] STATUS_RESET = 8'h1F;

  // ==========================================================================
  // Clock configuration fields
  localparam int PRESCALE_LSB = 5;
  localparam int PRESCALE_W = 3;
  localparam int SRC_BIT = 4;
  localparam int JUST_LSB = 2;
  localparam logic [7:0] CLOCK_RESET = 8'h04;

  // ==========================================================================
  // Channel codes
  localparam logic [4:0] CH_LAST_EXT = 5'h07;
  localparam logic [4:0] CH_REF_HIGH = 5'h1D;
  localparam logic [4:0] CH_REF_LOW = 5'h1E;
  localparam logic [4:0] CH_POWER_OFF = 5'h1F;

  // ==========================================================================
  // Conversion timing in converter clock ticks
  localparam logic [4:0] CONV_TICKS = 5'h10;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    JUST_TRUNC8 = 2'h0,
    JUST_RIGHT = 2'h1,
    JUST_LEFT = 2'h2,
    JUST_LEFT_SIGNED = 2'h3
  } justify_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_CONVERT = 2'h3
  } conv_state_e;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_STATUS = 3'h1,
    SEL_HIGH = 3'h2,
    SEL_LOW = 3'h3,
    SEL_CLOCK = 3'h4
  } reg_sel_e;

  typedef struct packed {
    logic start;
    logic conv_tick;
    logic power_down;
    logic ref_high;
    logic ref_low;
    logic [7:0] input_sel;
    logic [4:0] channel;
  } core_ctrl_s;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_s;

endpackage : adc_ctrl_pkg

/* File: design/adc_control_registers.sv */
// Purpose: Control, result and prescaler logic for a 10-bit converter
// Assumes: OSC_CLK and CONV_CODE are synchronous to CLK_SYS
// Notes on behaviour
// - Interrupts off: completion flag sets per conversion, clears on result read.
// - Interrupts on: completion flag never sets and reads zero.
// - Interrupts on: request per conversion, dropped on result read or control write.
// - Continuous bit set: convert repeatedly, update results after each one.
// - Continuous bit clear: one conversion per control register write.
// - Channel codes 0-7 route external inputs; 1D and 1E select references.
// - All-ones channel code powers the converter down.
// - Unused channel codes give an undefined result.
// - Left format: top eight bits high, low two bits top of low.
// - High read freezes results until low read, except truncation format.
// - Right format: top two bits low of high, lower eight low.
// - Left signed format equals left format with msb inverted.
// - Truncation: top eight bits in low register, high reads zero.
// - Prescaler divides by 1, 2, 4, 8, or 16 when top bit set.
// - Clock source one selects bus clock, zero oscillator; reset oscillator.
// - Justify field 00 trunc, 01 right, 10 left, 11 signed; reset right.
// - A control write with a channel code other than all ones starts a conversion of 16 converter clocks.
// - Continuous results overwrite unread ones, interlock permitting.
// - Stop state aborts any conversion and holds the block idle.

`timescale 1ns/1ps

module adc_control_registers (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // AXI4-Lite write data and response
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [adc_ctrl_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Analog core side
  input wire logic OSC_CLK,
  input wire logic STOP_MODE,
  input wire logic [9:0] CONV_CODE,
  output adc_ctrl_pkg::core_ctrl_s CORE_CTRL,
  output logic IRQ
);

  // ==========================================================================
  // Helper functions
  // Address to register select
  function automatic adc_ctrl_pkg::reg_sel_e decode_reg(input logic [adc_ctrl_pkg::ADDR_W-1:0] addr);
    case (addr[adc_ctrl_pkg::ADDR_W-1:2])
      adc_ctrl_pkg::IDX_STATUS_CONTROL: decode_reg = adc_ctrl_pkg::SEL_STATUS;
      adc_ctrl_pkg::IDX_RESULT_HIGH: decode_reg = adc_ctrl_pkg::SEL_HIGH;
      adc_ctrl_pkg::IDX_RESULT_LOW: decode_reg = adc_ctrl_pkg::SEL_LOW;
      adc_ctrl_pkg::IDX_CLOCK_CONFIG: decode_reg = adc_ctrl_pkg::SEL_CLOCK;
      default: decode_reg = adc_ctrl_pkg::SEL_NONE;
    endcase
  endfunction : decode_reg

  // Prescale code to last count of the divider
  function automatic logic [3:0] divide_last(input logic [2:0] code);
    if (code[2]) begin
      divide_last = 4'hF;
    end else begin
      case (code[1:0])
        2'h0: divide_last = 4'h0;
        2'h1: divide_last = 4'h1;
        2'h2: divide_last = 4'h3;
        default: divide_last = 4'h7;
      endcase
    end
  endfunction : divide_last

  // Place a 10-bit code into the two result bytes
  function automatic adc_ctrl_pkg::result_s format_result(input logic [9:0] code,
                                                         input adc_ctrl_pkg::justify_e mode);
    adc_ctrl_pkg::result_s r;
    r = '0;
    case (mode)
      adc_ctrl_pkg::JUST_TRUNC8: begin
        r.low = code[9:2];
      end
      adc_ctrl_pkg::JUST_RIGHT: begin
        r.high = {6'h00, code[9:8]};
        r.low = code[7:0];
      end
      adc_ctrl_pkg::JUST_LEFT: begin
        r.high = code[9:2];
        r.low = {code[1:0], 6'h00};
      end
      default: begin
        r.high = {~code[9], code[8:2]};
        r.low = {code[1:0], 6'h00};
      end
    endcase
    format_result = r;
  endfunction : format_result

  // ==========================================================================
  // Declarations
  logic aw_held_reg;
  logic [adc_ctrl_pkg::ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [7:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic ien_reg;
  logic cont_reg;
  logic [4:0] channel_reg;
  logic [2:0] prescale_reg;
  logic src_bus_reg;
  adc_ctrl_pkg::justify_e justify_reg;
  logic flag_reg;
  logic irq_reg;
  logic hold_low_reg;
  adc_ctrl_pkg::result_s result_reg;
  logic osc_q_reg;
  logic [3:0] div_cnt_reg;
  logic tick_out_reg;
  adc_ctrl_pkg::conv_state_e state_reg;
  adc_ctrl_pkg::conv_state_e state_next;
  logic [4:0] tick_cnt_reg;
  logic start_reg;
  logic [7:0] input_sel_reg;
  logic power_down_reg;
  logic ref_high_reg;
  logic ref_low_reg;
  logic do_write;
  logic ar_hs;
  adc_ctrl_pkg::reg_sel_e wr_sel;
  adc_ctrl_pkg::reg_sel_e rd_sel;
  logic wr_status;
  logic wr_clock;
  logic rd_high;
  logic rd_low;
  logic src_tick;
  logic adc_tick;
  logic done;

  // ==========================================================================
  // Bus handshakes and access decode
  assign S_AXI_AWREADY = CE && !aw_held_reg;
  assign S_AXI_WREADY = CE && !w_held_reg;
  assign S_AXI_ARREADY = CE && !rvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = {24'h000000, rdata_reg};
  assign S_AXI_RRESP = rresp_reg;
  assign do_write = CE && aw_held_reg && w_held_reg && !bvalid_reg;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wr_sel = decode_reg(aw_addr_reg);
  assign rd_sel = decode_reg(S_AXI_ARADDR);
  assign wr_status = do_write && w_lane0_reg && (wr_sel == adc_ctrl_pkg::SEL_STATUS);
  assign wr_clock = do_write && w_lane0_reg && (wr_sel == adc_ctrl_pkg::SEL_CLOCK);
  assign rd_high = ar_hs && (rd_sel == adc_ctrl_pkg::SEL_HIGH);
  assign rd_low = ar_hs && (rd_sel == adc_ctrl_pkg::SEL_LOW);

  // Write address and data capture, in either order
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA[7:0];
        w_lane0_reg <= S_AXI_WSTRB[0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= adc_ctrl_pkg::RESP_OKAY;
    end else if (CE) begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_sel == adc_ctrl_pkg::SEL_NONE) ? adc_ctrl_pkg::RESP_SLVERR : adc_ctrl_pkg::RESP_OKAY;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read data and response
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rresp_reg <= adc_ctrl_pkg::RESP_OKAY;
    end else if (CE) begin
      if (ar_hs) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= adc_ctrl_pkg::RESP_OKAY;
        case (rd_sel)
          adc_ctrl_pkg::SEL_STATUS: rdata_reg <= {flag_reg && !ien_reg, ien_reg, cont_reg, channel_reg};
          adc_ctrl_pkg::SEL_HIGH: rdata_reg <= result_reg.high;
          adc_ctrl_pkg::SEL_LOW: rdata_reg <= result_reg.low;
          adc_ctrl_pkg::SEL_CLOCK: rdata_reg <= {prescale_reg, src_bus_reg, justify_reg, 2'h0};
          default: begin
            rdata_reg <= 8'h00;
            rresp_reg <= adc_ctrl_pkg::RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Software registers
  // Status and control; the flag position of the write is ignored
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ien_reg <= adc_ctrl_pkg::STATUS_RESET[adc_ctrl_pkg::IEN_BIT];
      cont_reg <= adc_ctrl_pkg::STATUS_RESET[adc_ctrl_pkg::CONT_BIT];
      channel_reg <= adc_ctrl_pkg::STATUS_RESET[adc_ctrl_pkg::CH_LSB +: adc_ctrl_pkg::CH_W];
    end else if (CE && wr_status) begin
      ien_reg <= w_data_reg[adc_ctrl_pkg::IEN_BIT];
      cont_reg <= w_data_reg[adc_ctrl_pkg::CONT_BIT];
      channel_reg <= w_data_reg[adc_ctrl_pkg::CH_LSB +: adc_ctrl_pkg::CH_W];
    end
  end

  // Clock configuration
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      prescale_reg <= adc_ctrl_pkg::CLOCK_RESET[adc_ctrl_pkg::PRESCALE_LSB +: adc_ctrl_pkg::PRESCALE_W];
      src_bus_reg <= adc_ctrl_pkg::CLOCK_RESET[adc_ctrl_pkg::SRC_BIT];
      justify_reg <= adc_ctrl_pkg::justify_e'(adc_ctrl_pkg::CLOCK_RESET[adc_ctrl_pkg::JUST_LSB +: 2]);
    end else if (CE && wr_clock) begin
      prescale_reg <= w_data_reg[adc_ctrl_pkg::PRESCALE_LSB +: adc_ctrl_pkg::PRESCALE_W];
      src_bus_reg <= w_data_reg[adc_ctrl_pkg::SRC_BIT];
      justify_reg <= adc_ctrl_pkg::justify_e'(w_data_reg[adc_ctrl_pkg::JUST_LSB +: 2]);
    end
  end

  // ==========================================================================
  // Converter clock prescaler
  assign src_tick = src_bus_reg ? 1'b1 : (OSC_CLK && !osc_q_reg);
  assign adc_tick = src_tick && (div_cnt_reg >= divide_last(prescale_reg));

  // Divider count on each selected source edge
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      osc_q_reg <= 1'b0;
      div_cnt_reg <= 4'h0;
      tick_out_reg <= 1'b0;
    end else if (CE) begin
      osc_q_reg <= OSC_CLK;
      tick_out_reg <= adc_tick;
      if (adc_tick) begin
        div_cnt_reg <= 4'h0;
      end else if (src_tick) begin
        div_cnt_reg <= div_cnt_reg + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Conversion sequencing
  // First tick lands at any phase, so end on the tick after sixteen full periods
  assign done = (state_reg == adc_ctrl_pkg::ST_CONVERT) && adc_tick &&
                (tick_cnt_reg == adc_ctrl_pkg::CONV_TICKS);

  // Next state
  always_comb begin
    state_next = state_reg;
    if (STOP_MODE) begin
      state_next = adc_ctrl_pkg::ST_IDLE;
    end else if (wr_status) begin
      // Restart discards any conversion in flight
      if (w_data_reg[adc_ctrl_pkg::CH_LSB +: adc_ctrl_pkg::CH_W] == adc_ctrl_pkg::CH_POWER_OFF) begin
        state_next = adc_ctrl_pkg::ST_IDLE;
      end else begin
        state_next = adc_ctrl_pkg::ST_START;
      end
    end else begin
      unique case (state_reg)
        adc_ctrl_pkg::ST_IDLE: begin
          if (cont_reg && channel_reg != adc_ctrl_pkg::CH_POWER_OFF) begin
            state_next = adc_ctrl_pkg::ST_START;
          end
        end
        adc_ctrl_pkg::ST_START: state_next = adc_ctrl_pkg::ST_CONVERT;
        adc_ctrl_pkg::ST_CONVERT: begin
          if (done) begin
            state_next = cont_reg ? adc_ctrl_pkg::ST_START : adc_ctrl_pkg::ST_IDLE;
          end
        end
        default: state_next = adc_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // State, tick count and start pulse
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_reg <= adc_ctrl_pkg::ST_IDLE;
      tick_cnt_reg <= 5'h00;
      start_reg <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      start_reg <= (state_next == adc_ctrl_pkg::ST_START);
      if (state_reg != adc_ctrl_pkg::ST_CONVERT) begin
        tick_cnt_reg <= 5'h00;
      end else if (adc_tick) begin
        tick_cnt_reg <= tick_cnt_reg + 5'h01;
      end
    end
  end

  // ==========================================================================
  // Completion flag, interrupt request and results
  // Flag: set wins over a read in the same cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      flag_reg <= 1'b0;
    end else if (CE) begin
      if (done && !ien_reg) begin
        flag_reg <= 1'b1;
      end else if (rd_high || rd_low || ien_reg) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // Interrupt request: set wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_reg <= 1'b0;
    end else if (CE) begin
      if (done && ien_reg) begin
        irq_reg <= 1'b1;
      end else if (rd_high || rd_low || wr_status) begin
        irq_reg <= 1'b0;
      end
    end
  end

  // High/low interlock
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      hold_low_reg <= 1'b0;
    end else if (CE) begin
      if (rd_low || justify_reg == adc_ctrl_pkg::JUST_TRUNC8) begin
        hold_low_reg <= 1'b0;
      end else if (rd_high) begin
        hold_low_reg <= 1'b1;
      end
    end
  end

  // Result latch; unused channel codes pass the core's code as it comes
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      result_reg <= '0;
    end else if (CE && done && !hold_low_reg) begin
      result_reg <= format_result(CONV_CODE, justify_reg);
    end
  end

  // ==========================================================================
  // Analog core controls
  // Channel routing and power-down decode
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      input_sel_reg <= 8'h00;
      power_down_reg <= 1'b1;
      ref_high_reg <= 1'b0;
      ref_low_reg <= 1'b0;
    end else if (CE) begin
      input_sel_reg <= (channel_reg <= adc_ctrl_pkg::CH_LAST_EXT) ? (8'h01 << channel_reg[2:0]) : 8'h00;
      ref_high_reg <= (channel_reg == adc_ctrl_pkg::CH_REF_HIGH);
      ref_low_reg <= (channel_reg == adc_ctrl_pkg::CH_REF_LOW);
      power_down_reg <= (channel_reg == adc_ctrl_pkg::CH_POWER_OFF) || STOP_MODE;
    end
  end

  // Output assembly from flip-flops
  assign CORE_CTRL.start = start_reg;
  assign CORE_CTRL.conv_tick = tick_out_reg;
  assign CORE_CTRL.power_down = power_down_reg;
  assign CORE_CTRL.ref_high = ref_high_reg;
  assign CORE_CTRL.ref_low = ref_low_reg;
  assign CORE_CTRL.input_sel = input_sel_reg;
  assign CORE_CTRL.channel = channel_reg;
  assign IRQ = irq_reg;

endmodule : adc_control_registers

/* File: verif/adc_ctrl_monitor.sv */
// Purpose: Port level checks of the converter control block
// Assumes: Single clock domain, reset active high
// Notes: Bound to the block at the foot of this file
`timescale 1ns/1ps
module adc_ctrl_monitor (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Bus handshakes
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  // Core side
  input wire logic STOP_MODE,
  input wire adc_ctrl_pkg::core_ctrl_s CORE_CTRL,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic wr_st;
  logic rd_st;
  // ==========================================
  // Whether the last write and read addressed the status register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) wr_st <= 1'b0;
    else if (S_AXI_AWVALID && S_AXI_AWREADY) wr_st <= S_AXI_AWADDR[7:2] == adc_ctrl_pkg::IDX_STATUS_CONTROL;
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) rd_st <= 1'b0;
    else if (S_AXI_ARVALID && S_AXI_ARREADY) rd_st <= S_AXI_ARADDR[7:2] == adc_ctrl_pkg::IDX_STATUS_CONTROL;
  end
  // ==========================================
  // Assertions
  AST_START_PULSE: assert property (CORE_CTRL.start |=> !CORE_CTRL.start)
    else $error("start pulse longer than one cycle");
  AST_WRITE_STARTS: assert property ($rose(S_AXI_BVALID) && wr_st && !$past(STOP_MODE)
    && CORE_CTRL.channel != adc_ctrl_pkg::CH_POWER_OFF |-> CORE_CTRL.start) else $error("write gave no start");
  AST_WRITE_DROPS_IRQ: assert property ($rose(S_AXI_BVALID) && wr_st |-> !IRQ)
    else $error("request kept after control write");
  AST_FLAG_OFF_WITH_IEN: assert property (S_AXI_RVALID && rd_st && S_AXI_RDATA[6] |-> !S_AXI_RDATA[7])
    else $error("flag set with interrupts on");
  AST_POWER_DOWN: assert property ($past(CORE_CTRL.channel == 5'h1F || STOP_MODE) |-> CORE_CTRL.power_down)
    else $error("converter not powered down");
  AST_INPUT_ONEHOT: assert property ($stable(CORE_CTRL.channel) |-> CORE_CTRL.input_sel ==
    (CORE_CTRL.channel <= 5'h07 ? 8'h01 << CORE_CTRL.channel : 8'h00)) else $error("input select wrong");
  AST_REF_SEL: assert property ($stable(CORE_CTRL.channel) |-> CORE_CTRL.ref_high == (CORE_CTRL.channel == 5'h1D)
    && CORE_CTRL.ref_low == (CORE_CTRL.channel == 5'h1E)) else $error("reference select wrong");
  AST_STOP_NO_START: assert property (STOP_MODE ##1 STOP_MODE |-> !CORE_CTRL.start)
    else $error("start during stop");
  AST_RDATA_UPPER: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_READ_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
endmodule : adc_ctrl_monitor

bind adc_control_registers adc_ctrl_monitor i_adc_ctrl_monitor (.CLK_SYS(CLK_SYS), .RST(RST),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RDATA(S_AXI_RDATA),
  .STOP_MODE(STOP_MODE), .CORE_CTRL(CORE_CTRL), .IRQ(IRQ));

/* File: verif/adc_core_model.sv */
// Purpose: Behavioural analog core and input multiplexer
// Assumes: Code latched one cycle after each start pulse
// Notes: Output churns while powered down
`timescale 1ns/1ps
module adc_core_model (
  // Clock
  input wire logic clk,
  // Control and bench code
  input wire adc_ctrl_pkg::core_ctrl_s ctrl,
  input wire logic [9:0] next_code,
  // Code to the block
  output logic [9:0] conv_code = 10'h000
);
  logic start_q = 1'b0;
  // Sample once the routing controls have settled
  always_ff @(posedge clk) start_q <= ctrl.start;
  // Reference nodes give full and zero scale
  always_ff @(posedge clk) begin
    if (start_q) conv_code <= ctrl.ref_high ? 10'h3FF : ctrl.ref_low ? 10'h000 : next_code;
    else if (ctrl.power_down) conv_code <= ~conv_code;
  end
endmodule : adc_core_model

/* File: verif/tb.sv */
// Purpose: Self-checking bench of the converter control block
// Assumes: Bus clock 20 MHz, seed 57
// Notes: Timing checked through IRQ, formats through the flag
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, aw = 1'b0, w = 1'b0, b = 1'b0, ar = 1'b0, r = 1'b0;
  logic stp = 1'b0, osc = 1'b0, osc_run = 1'b0, awr, wrd, bv, arr, rv, irq;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [1:0] br, rr, resp, m;
  logic [9:0] code = 10'h000, conv;
  logic [2:0] ch;
  logic [15:0] e;
  adc_ctrl_pkg::core_ctrl_s core;
  int seed = 57, n_mismatch = 0, cmp_count = 0, n, k, d;
  // Clocks
  always #25 clk = ~clk;
  always @(posedge clk) if (osc_run) osc <= ~osc;
  adc_control_registers i_adc_control_registers (.CLK_SYS(clk), .RST(rst), .CE(1'b1),
    .S_AXI_AWVALID(aw), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(w), .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(b), .S_AXI_BRESP(br), .S_AXI_ARVALID(ar), .S_AXI_ARREADY(arr),
    .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rv), .S_AXI_RREADY(r), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rr), .OSC_CLK(osc), .STOP_MODE(stp), .CONV_CODE(conv), .CORE_CTRL(core), .IRQ(irq));
  adc_core_model i_adc_core_model (.clk(clk), .ctrl(core), .next_code(code), .conv_code(conv));
  // ==========================================
  // Tasks
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    aw <= 1'b1; w <= 1'b1; awa <= a; wd <= {24'h000000, dat}; b <= 1'b1;
    forever begin
      @(posedge clk);
      if (aw && awr) aw <= 1'b0;
      if (w && wrd) w <= 1'b0;
      if (bv === 1'b1) break;
    end
    resp = br;
    b <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    ar <= 1'b1; ara <= a; r <= 1'b1;
    forever begin
      @(posedge clk);
      if (ar && arr) ar <= 1'b0;
      if (rv === 1'b1) break;
    end
    v = rdat; resp = rr; r <= 1'b0;
  endtask : rd
  task wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin @(posedge clk); n++; end
  endtask : wait_irq
  function automatic logic [15:0] fmt(input logic [9:0] c, input logic [1:0] md);
    case (md)
      2'h0: return {8'h00, c[9:2]};
      2'h1: return {6'h00, c};
      2'h2: return {c, 6'h00};
      default: return {~c[9], c[8:0], 6'h00};
    endcase
  endfunction : fmt
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'hF0 + 8'(4 * i));
      chk("reset value", i == 0 ? 32'h1F : i == 3 ? 32'h04 : 32'h0, v);
    end
    rd(8'h00);
    chk("unmapped resp", 32'h2, {30'h0, resp});
    wr(8'h00, 8'h00);
    chk("unmapped bresp", 32'h2, {30'h0, resp});
    $display("test reset done");
    // Formats, flag mode, status bit7 written zero
    for (int i = 0; i < 8; i++) begin
      m = 2'(i); code <= 10'($random(seed)); ch = 3'($random(seed));
      wr(8'hFC, {3'b000, 1'b1, m, 2'b00});
      wr(8'hF0, {5'h00, ch});
      chk("bresp", 32'h0, {30'h0, resp});
      k = 0;
      do begin rd(8'hF0); k++; end while (v[7] !== 1'b1 && k < 20);
      chk("flag set", {24'h0, 5'b10000, ch}, v);
      e = fmt(code, m);
      rd(8'hF4); chk("high", {24'h0, e[15:8]}, v);
      rd(8'hF8); chk("low", {24'h0, e[7:0]}, v);
      rd(8'hF0); chk("flag clear", {29'h0, ch}, v);
    end
    $display("test formats done");
    // Reference nodes, entered from power-down
    wr(8'hF0, 8'h1F);
    wr(8'hFC, 8'h14);
    wr(8'hF0, 8'h1D);
    repeat (40) @(posedge clk);
    rd(8'hF4);
    chk("ref high", 32'h3, v);
    rd(8'hF8);
    chk("ref high low byte", 32'hFF, v);
    wr(8'hF0, 8'h1E);
    repeat (40) @(posedge clk);
    rd(8'hF4);
    chk("ref low", 32'h0, v);
    rd(8'hF8);
    chk("ref low low byte", 32'h0, v);
    code <= 10'h2A5;
    wr(8'hFC, 8'h14); wr(8'hF0, 8'h20);
    repeat (40) @(posedge clk);
    rd(8'hF4); chk("frozen high", 32'h2, v);
    code <= 10'h15A;
    repeat (60) @(posedge clk);
    rd(8'hF8); chk("frozen low", 32'hA5, v);
    repeat (40) @(posedge clk);
    rd(8'hF4); chk("new high", 32'h1, v);
    rd(8'hF8); chk("new low", 32'h5A, v);
    wr(8'hF0, 8'h1F);
    $display("test interlock done");
    for (int p = 0; p < 8; p++) begin
      if (p == 5 || p == 6) continue;
      d = p > 3 ? 16 : 1 << p;
      wr(8'hFC, {3'(p), 5'b10100});
      wr(8'hF0, 8'h40);
      wait_irq(400);
      chk("duration", 32'h1, {31'h0, n >= 16 * d - 1 && n <= 17 * d + 4});
      rd(8'hF0); chk("flag with ien", 32'h40, v);
      rd(8'hF8); chk("irq read clear", 32'h0, {31'h0, irq});
    end
    wr(8'hFC, 8'h14); wr(8'hF0, 8'h40); wait_irq(100);
    wr(8'hF0, 8'h5F); chk("irq write clear", 32'h0, {31'h0, irq});
    wait_irq(100); chk("power off", 32'd100, n);
    $display("test prescaler done");
    wr(8'hFC, 8'h04); wr(8'hF0, 8'h40); wait_irq(100);
    chk("osc stopped", 32'd100, n);
    chk("tick stopped", 32'h0, {31'h0, core.conv_tick});
    osc_run <= 1'b1;
    wait_irq(200);
    chk("osc conv", 32'h1, {31'h0, n >= 30 && n <= 40});
    rd(8'hF8);
    wr(8'hFC, 8'hF4); wr(8'hF0, 8'h40);
    repeat (100) @(posedge clk);
    stp <= 1'b1;
    repeat (10) @(posedge clk);
    stp <= 1'b0;
    wait_irq(400); chk("stop abort", 32'd400, n);
    $display("test clock and stop done");
    test_done;
  end
endmodule : tb
